// file: hdl/dpac_pkg.sv
// constants and carrier types of the phase accumulator synthesis core
// assumes one 100 MHz system clock; reference clock arrives as a sampled level
`default_nettype none
package dpac_pkg;

    localparam int unsigned ACC_W   = 32;
    localparam int unsigned PHASE_W = 14;
    localparam int unsigned DAC_W   = 10;
    localparam int unsigned POFF_W  = 5;
    localparam int unsigned WAIT_W  = 5;
    localparam int unsigned GAP_W   = 8;

    // offset-binary sample codes, magnitude limit and phase constants
    localparam logic [DAC_W-1:0]   MIDSCALE = 10'h200;
    localparam logic [8:0]         MAG_MAX  = 9'h1FF;
    localparam logic [PHASE_W-1:0] QUARTER  = 14'h1000;
    localparam logic [PHASE_W:0]   HALF_SPAN = 15'h2000;

    // latency from update strobe to output, in reference ticks
    localparam int unsigned FREQ_LAT_CYC   = 18;
    localparam int unsigned PHASE_LAT_CYC  = 13;
    localparam int unsigned FREQ_PIPE_CYC  = 3;
    localparam int unsigned PHASE_PIPE_CYC = 2;
    localparam logic [WAIT_W-1:0] FREQ_WAIT =
        WAIT_W'(FREQ_LAT_CYC - FREQ_PIPE_CYC - 1);
    localparam logic [WAIT_W-1:0] PHASE_WAIT =
        WAIT_W'(PHASE_LAT_CYC - PHASE_PIPE_CYC - 1);

    // reference rate supervision; longest period rounds down
    localparam int unsigned SYS_CLK_KHZ    = 100000;
    localparam int unsigned REF_MIN_KHZ    = 1000;
    localparam logic [GAP_W-1:0] MAX_PERIOD_CYC =
        GAP_W'(SYS_CLK_KHZ / REF_MIN_KHZ);

    // least master reset width the controller must give, reference ticks
    localparam int unsigned RESET_MIN_CYC  = 5;

    typedef struct packed {
        logic [POFF_W-1:0] phase;
        logic              power_down;
        logic [1:0]        control;
        logic [ACC_W-1:0]  freq;
    } dpac_prog_t;

    typedef enum logic [2:0] {
        MODE_RUN  = 3'b001,
        MODE_PD   = 3'b010,
        MODE_SLOW = 3'b100
    } dpac_mode_t;

endpackage
`default_nettype wire

// file: hdl/dpac_core.sv
// numerically controlled oscillator core: accumulator, cosine map, dac feed
// assumes the programming word arrives whole from an outside loader and that
// reference_clock, tuning_update_strobe and master_reset are synchronous
`timescale 1ns/1ps
`default_nettype none
module dpac_core
    import dpac_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              master_reset,
    input  wire logic              reference_clock,
    input  wire logic              prog_load,
    input  wire dpac_prog_t        prog_word,
    input  wire logic              tuning_update_strobe,
    output logic [DAC_W-1:0]       dac_sample,
    output logic                   sample_valid,
    output logic                   powered_down,
    output logic                   clock_too_slow
);

////////////////////////////////////////////////////////////////////////////
// reset release

    logic rst_meta;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

////////////////////////////////////////////////////////////////////////////
// input side: tick detect, rate supervision, data input register

    logic             ref_q;
    logic             strobe_q;
    logic [GAP_W-1:0] gap;
    logic             slow;
    dpac_prog_t       data_reg;
    logic             next_ref_q;
    logic             next_strobe_q;
    logic [GAP_W-1:0] next_gap;
    logic             next_slow;
    dpac_prog_t       next_data_reg;
    logic             tick;
    logic             update;

    assign tick   = reference_clock & ~ref_q;
    assign update = tuning_update_strobe & ~strobe_q;

    always_comb begin
        next_ref_q    = reference_clock;
        next_strobe_q = tuning_update_strobe;
        next_gap      = gap;
        next_slow     = slow;
        next_data_reg = data_reg;
        if (tick) begin
            next_gap = '0;
            // period within limit brings the core back by itself
            if (gap < MAX_PERIOD_CYC) begin
                next_slow = 1'b0;
            end
        end else if (gap != MAX_PERIOD_CYC) begin
            next_gap = gap + 1'b1;
        end else begin
            // no edge for a full minimum period: clock too slow
            next_slow = 1'b1;
        end
        // master reset leaves the loaded word alone
        if (prog_load) begin
            next_data_reg = prog_word;
        end
        if (master_reset) begin
            next_slow = 1'b0;
            next_gap  = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_q    <= 1'b0;
            strobe_q <= 1'b0;
            gap      <= '0;
            slow     <= 1'b0;
            data_reg <= '0;
        end else begin
            ref_q    <= next_ref_q;
            strobe_q <= next_strobe_q;
            gap      <= next_gap;
            slow     <= next_slow;
            data_reg <= next_data_reg;
        end
    end

////////////////////////////////////////////////////////////////////////////
// core: update latency, mode, accumulator and cosine pipeline

    dpac_mode_t          mode;
    logic                pd_bit;
    logic [ACC_W-1:0]    pend_freq;
    logic [POFF_W-1:0]   pend_phase;
    logic                freq_pend;
    logic                phase_pend;
    logic [WAIT_W-1:0]   freq_wait;
    logic [WAIT_W-1:0]   phase_wait;
    logic [ACC_W-1:0]    incr;
    logic [POFF_W-1:0]   poff;
    logic [ACC_W-1:0]    acc;
    logic [PHASE_W-1:0]  trunc;
    logic [DAC_W-1:0]    sample;
    logic                valid;

    dpac_mode_t          next_mode;
    logic                next_pd_bit;
    logic [ACC_W-1:0]    next_pend_freq;
    logic [POFF_W-1:0]   next_pend_phase;
    logic                next_freq_pend;
    logic                next_phase_pend;
    logic [WAIT_W-1:0]   next_freq_wait;
    logic [WAIT_W-1:0]   next_phase_wait;
    logic [ACC_W-1:0]    next_incr;
    logic [POFF_W-1:0]   next_poff;
    logic [ACC_W-1:0]    next_acc;
    logic [PHASE_W-1:0]  next_trunc;
    logic [DAC_W-1:0]    next_sample;
    logic                next_valid;

    logic [PHASE_W-1:0]  shifted;
    logic [PHASE_W-1:0]  pq;
    logic [PHASE_W-1:0]  xq;
    logic [2*PHASE_W-1:0] prod;
    logic [8:0]          mag;
    logic                run_tick;

    // quarter-turn advance turns a sine fold into cosine
    always_comb begin
        pq   = trunc + QUARTER;
        xq   = {1'b0, pq[PHASE_W-2:0]};
        // parabola per half turn; cheap, a few percent off a true cosine
        prod = xq * PHASE_W'(HALF_SPAN - {1'b0, xq});
        mag  = prod[24] ? MAG_MAX : prod[23:15];
    end

    assign run_tick = tick & (mode == MODE_RUN);

    always_comb begin
        next_pd_bit     = pd_bit;
        next_pend_freq  = pend_freq;
        next_pend_phase = pend_phase;
        next_freq_pend  = freq_pend;
        next_phase_pend = phase_pend;
        next_freq_wait  = freq_wait;
        next_phase_wait = phase_wait;
        next_incr       = incr;
        next_poff       = poff;
        next_acc        = acc;
        next_trunc      = trunc;
        next_sample     = sample;
        next_valid      = 1'b0;
        shifted         = '0;

        // latency counters run on reference ticks
        if (tick && freq_pend) begin
            if (freq_wait == '0) begin
                next_incr      = pend_freq;
                next_freq_pend = 1'b0;
            end else begin
                next_freq_wait = freq_wait - 1'b1;
            end
        end
        if (tick && phase_pend) begin
            if (phase_wait == '0) begin
                next_poff       = pend_phase;
                next_phase_pend = 1'b0;
            end else begin
                next_phase_wait = phase_wait - 1'b1;
            end
        end
        // accumulator untouched here, so the wave stays continuous
        if (update) begin
            next_pend_freq  = data_reg.freq;
            next_pend_phase = data_reg.phase;
            next_freq_pend  = 1'b1;
            next_phase_pend = 1'b1;
            next_freq_wait  = FREQ_WAIT;
            next_phase_wait = PHASE_WAIT;
            next_pd_bit     = data_reg.power_down;
        end

        if (run_tick) begin
            // carry out of the top is simply dropped
            next_acc   = acc + incr;
            shifted    = {poff, {(PHASE_W-POFF_W){1'b0}}};
            next_trunc = acc[ACC_W-1 -: PHASE_W]
                       + shifted;
            next_sample = pq[PHASE_W-1]
                        ? MIDSCALE - {1'b0, mag}
                        : MIDSCALE + {1'b0, mag};
            next_valid  = 1'b1;
        end else if (mode != MODE_RUN) begin
            // idle dac sits at midscale while shut down
            next_sample = MIDSCALE;
        end

        // clearing acc and pipeline lets phase zero walk out
        if (master_reset) begin
            next_pd_bit     = 1'b0;
            next_pend_freq  = '0;
            next_pend_phase = '0;
            next_freq_pend  = 1'b0;
            next_phase_pend = 1'b0;
            next_freq_wait  = '0;
            next_phase_wait = '0;
            next_incr       = '0;
            next_poff       = '0;
            next_acc        = '0;
            next_trunc      = '0;
            next_sample     = MIDSCALE;
            next_valid      = 1'b0;
        end
    end

    // manual power-down outranks the slow-clock shutdown
    always_comb begin
        case (mode)
            MODE_RUN,
            MODE_PD,
            MODE_SLOW: begin
                if (next_pd_bit) begin
                    next_mode = MODE_PD;
                end else if (next_slow) begin
                    next_mode = MODE_SLOW;
                end else begin
                    next_mode = MODE_RUN;
                end
            end
            default: begin
                next_mode = MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode       <= MODE_RUN;
            pd_bit     <= 1'b0;
            pend_freq  <= '0;
            pend_phase <= '0;
            freq_pend  <= 1'b0;
            phase_pend <= 1'b0;
            freq_wait  <= '0;
            phase_wait <= '0;
            incr       <= '0;
            poff       <= '0;
            acc        <= '0;
            trunc      <= '0;
            sample     <= MIDSCALE;
            valid      <= 1'b0;
        end else begin
            mode       <= next_mode;
            pd_bit     <= next_pd_bit;
            pend_freq  <= next_pend_freq;
            pend_phase <= next_pend_phase;
            freq_pend  <= next_freq_pend;
            phase_pend <= next_phase_pend;
            freq_wait  <= next_freq_wait;
            phase_wait <= next_phase_wait;
            incr       <= next_incr;
            poff       <= next_poff;
            acc        <= next_acc;
            trunc      <= next_trunc;
            sample     <= next_sample;
            valid      <= next_valid;
        end
    end

////////////////////////////////////////////////////////////////////////////
// outputs

    assign dac_sample     = sample;
    assign sample_valid   = valid;
    assign powered_down   = (mode != MODE_RUN);
    assign clock_too_slow = (mode == MODE_SLOW);

endmodule
`default_nettype wire

// file: bench/dpac_core_sva.sv
// port checks on the synthesis core
// assumes one sys_clk domain; nrst low disables every check
`timescale 1ns/1ps
`default_nettype none
module dpac_core_sva
    import dpac_pkg::*;
(
    input wire logic             sys_clk,
    input wire logic             nrst,
    input wire logic             master_reset,
    input wire logic             reference_clock,
    input wire logic [DAC_W-1:0] dac_sample,
    input wire logic             sample_valid,
    input wire logic             powered_down,
    input wire logic             clock_too_slow
);
    logic       ref_q;
    logic [7:0] gap;
    wire        tick = reference_clock && !ref_q;
    // idle count saturates so a long stall never wraps under the limit
    always_ff @(posedge sys_clk or negedge nrst)
        if (!nrst) begin
            ref_q <= 1'b0;
            gap <= 8'h00;
        end else begin
            ref_q <= reference_clock;
            gap <= (master_reset || tick) ? 8'h00 : gap + 8'(gap != 8'hFF);
        end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_reset_parks: assert property (
        master_reset && $past(master_reset)
        |=> dac_sample == MIDSCALE && !sample_valid)
        else $error("not parked");
    a_reset_flags: assert property (
        master_reset && $past(master_reset)
        |=> !powered_down && !clock_too_slow)
        else $error("flags kept");
    a_valid_pulse: assert property (
        sample_valid |=> !sample_valid)
        else $error("valid too wide");
    a_valid_tick: assert property (
        sample_valid |-> $past(reference_clock)
        && !$past(reference_clock, 2))
        else $error("sample without tick");
    // mode one cycle back is the mode the tick was taken in
    a_pd_silent: assert property (
        $past(powered_down) |-> !sample_valid)
        else $error("sample in power-down");
    a_slow_is_pd: assert property (
        clock_too_slow |-> powered_down)
        else $error("slow without power-down");
    a_slow_late: assert property (
        $rose(clock_too_slow) |-> gap >= 8'h63)
        else $error("slow flag early");
    a_slow_soon: assert property (
        gap == 8'h6E |-> clock_too_slow)
        else $error("slow flag missing");
    a_slow_wake: assert property (
        clock_too_slow && tick && gap < 8'h5A
        |-> ##[1:2] !clock_too_slow)
        else $error("no wake");
endmodule
bind dpac_core dpac_core_sva i_sva (.sys_clk, .nrst, .master_reset,
    .reference_clock, .dac_sample, .sample_valid, .powered_down,
    .clock_too_slow);
`default_nettype wire

// file: bench/dpac_dac_model.sv
// far-side converter: keeps the last word handed over and counts words
// assumes sample_valid is a one-cycle strobe in the sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module dpac_dac_model
    import dpac_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic [DAC_W-1:0] dac_sample,
    input  wire logic             sample_valid,
    output var  logic [DAC_W-1:0] held,
    output var  int               n_conv
);
    // output rests at midscale until the first word
    always @(posedge sys_clk or negedge nrst)
        if (!nrst) begin
            held <= MIDSCALE;
            n_conv <= 0;
        end else if (sample_valid) begin
            held <= dac_sample;
            n_conv <= n_conv + 1;
        end
endmodule
`default_nettype wire

// file: bench/test_dds_phase_accumulator_core.sv
// bench: integer model of the core compared at every dac sample while the model is on
// assumes the dac model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module test_dds_phase_accumulator_core;
    import dpac_pkg::*;
    logic             sys_clk = 1'b0, nrst = 1'b0, master_reset = 1'b0;
    logic             reference_clock = 1'b0, prog_load = 1'b0;
    logic             tuning_update_strobe = 1'b0;
    dpac_prog_t       prog_word = '0, w;
    logic [DAC_W-1:0] dac_sample, held;
    logic             sample_valid, powered_down, clock_too_slow;
    logic [31:0]      acc, incr, pf;
    logic [13:0]      trunc;
    logic [4:0]       off, pp;
    logic [9:0]       exp_q[$];
    int               failures = 0, n_tests = 0, cnt, mdl_on, n_conv, k;
    always #5 sys_clk = ~sys_clk;
    dpac_core i_dut (.sys_clk, .nrst, .master_reset, .reference_clock,
        .prog_load, .prog_word, .tuning_update_strobe, .dac_sample,
        .sample_valid, .powered_down, .clock_too_slow);
    dpac_dac_model i_dac (.sys_clk, .nrst, .dac_sample, .sample_valid,
        .held, .n_conv);
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    function automatic logic [9:0] cosv(input logic [13:0] t);
        logic [13:0] pq;
        logic [31:0] m;
        pq = t + 14'h1000;
        m = ({19'h0, pq[12:0]} * (32'h2000 - pq[12:0])) >> 15;
        m = (m > 32'h1FF) ? 32'h1FF : m;
        return pq[13] ? 10'h200 - m[9:0] : 10'h200 + m[9:0];
    endfunction
    task automatic mdl_clr();
        acc = '0;
        incr = '0;
        trunc = '0;
        off = '0;
        cnt = 99;
        mdl_on = 1;
        exp_q.delete();
    endtask
    // model steps when the bench raises the reference level
    task automatic tick();
        reference_clock = 1'b1;
        if (mdl_on != 0) begin
            exp_q.push_back(cosv(trunc));
            trunc = acc[31:18] + {off, 9'h000};
            acc = acc + incr;
            cnt++;
            if (cnt == 11) off = pp;
            if (cnt == 15) incr = pf;
        end
        step(2);
        reference_clock = 1'b0;
        step(2);
    endtask
    task automatic load_upd(input dpac_prog_t v, input logic ld);
        prog_word = v;
        prog_load = ld;
        step(1);
        prog_load = 1'b0;
        tuning_update_strobe = 1'b1;
        pf = v.freq;
        pp = v.phase;
        cnt = 0;
        step(1);
        tuning_update_strobe = 1'b0;
        step(1);
    endtask
    task automatic mreset();
        master_reset = 1'b1;
        mdl_on = 0;
        // reference keeps running through the reset window
        repeat (RESET_MIN_CYC) tick();
        check("rst code", dac_sample, MIDSCALE);
        check("rst pd", powered_down, 1'b0);
        check("drained", exp_q.size(), 0);
        master_reset = 1'b0;
        mdl_clr();
        step(2);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk)
        if (sample_valid === 1'b1 && mdl_on != 0)
            check("sample", dac_sample, exp_q.pop_front());
    initial begin
        void'($urandom(65638));
        mdl_clr();
        step(5);
        nrst = 1'b1;
        step(3);
        repeat (4) tick();
        check("zero phase", held, 10'h3FF);
        // k2 is cut short so k3 restarts the pending wait
        for (k = 0; k < 6; k++) begin
            w = {5'($urandom), 3'b000, 32'($urandom)};
            if (k == 0) w.freq = 32'hFFFF_FFFF;
            if (k == 1) w.freq = 32'h8000_0000;
            load_upd(w, 1'b1);
            repeat ((k == 2) ? 5 : 22) tick();
        end
        mreset();
        load_upd(w, 1'b0);
        repeat (22) tick();
        mdl_on = 0;
        w.power_down = 1'b1;
        load_upd(w, 1'b1);
        k = n_conv;
        repeat (5) tick();
        check("pd flag", powered_down, 1'b1);
        check("pd words", n_conv, k);
        check("pd code", dac_sample, MIDSCALE);
        mreset();
        mdl_on = 0;
        // flag must not come before a full minimum period has passed
        step(95);
        check("slow early", clock_too_slow, 1'b0);
        step(15);
        check("slow flag", clock_too_slow, 1'b1);
        repeat (3) tick();
        check("slow clear", clock_too_slow, 1'b0);
        k = n_conv;
        repeat (2) tick();
        check("resumed", n_conv > k, 1'b1);
        check("left over", exp_q.size(), 0);
        close_out();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
